// File: rtl/tefl_pkg.sv
package tefl_pkg;
   // ************************************************************
   // Counter limits and reset values
   // ************************************************************
   localparam int          CNT_W        = 16;         // Counter width
   localparam logic [15:0] CNT_ZERO     = 16'h0000;   // Wrap target and center of period
   localparam logic [15:0] CNT_MAX      = 16'hffff;   // Free-running top
   localparam logic [15:0] CNT_RST      = 16'h0000;   // Counter after reset
   localparam logic [15:0] MOD_NONE     = 16'h0000;   // Modulus meaning no limit
   localparam int          NUM_CH       = 2;          // Default channel count

   // ************************************************************
   // Channel edge select codes
   // ************************************************************
   localparam logic [1:0]  EDGE_OFF     = 2'h0;       // Capture disabled
   localparam logic [1:0]  EDGE_RISE    = 2'h1;       // Rising edges only
   localparam logic [1:0]  EDGE_FALL    = 2'h2;       // Falling edges only
   localparam logic [1:0]  EDGE_ANY     = 2'h3;       // Both edges

   // ************************************************************
   // Channel modes
   // ************************************************************
   typedef enum logic [1:0] {
      TEFL_CAPTURE,
      TEFL_COMPARE,
      TEFL_EDGE_PWM,
      TEFL_CENTER_PWM
   } tefl_ch_mode_type;
endpackage : tefl_pkg

// File: rtl/tefl_timer_event_flags.sv
// What this block does
// - Unlimited up-count runs 0000 to ffff, wraps
// - Free-running overflow flag sets on ffff wrap
// - Modulus up-count overflow sets at modulus to zero
// - Up/down overflow sets at modulus turnaround
// - Zero count is center between overflows
// - Edge select picks rise, fall, both, none
// - Capture channel flag sets on selected edge
// - Compare channel flag sets on counter match
// - Edge PWM flag sets once per period
// - Center PWM flag sets on both matches
// - Clear needs read-while-set then zero write
// - Enabled set flag holds level interrupt request
`timescale 1ns/10ps
`default_nettype none
module tefl_timer_event_flags #(
   parameter int NUM_CH = tefl_pkg::NUM_CH               // Number of channels
) (
   input  wire logic                 clock,              // 250 MHz counting clock
   input  wire logic                 rst_n,              // Async reset, active low
   input  wire logic [15:0]          modulus,            // Modulus limit, zero means none
   input  wire logic                 center_aligned_pwm, // Up/down counting select
   input  wire logic                 overflow_irq_enable,// Overflow interrupt enable
   input  wire logic                 ovf_flag_read,      // Software read of overflow flag
   input  wire logic                 ovf_flag_write_zero,// Software writes zero to overflow flag
   input  wire logic [2*NUM_CH-1:0]  channel_mode,       // Per channel mode code
   input  wire logic [2*NUM_CH-1:0]  channel_edge_select,// Per channel capture edge
   input  wire logic [16*NUM_CH-1:0] channel_value,      // Per channel compare value
   input  wire logic [NUM_CH-1:0]    channel_pin,        // Channel inputs from pins
   input  wire logic [NUM_CH-1:0]    channel_irq_enable, // Channel interrupt enables
   input  wire logic [NUM_CH-1:0]    ch_flag_read,       // Software read of channel flags
   input  wire logic [NUM_CH-1:0]    ch_flag_write_zero, // Software writes zero to channel flags
   output logic [15:0]               counter,            // Timer count
   output logic                      count_down,         // High while counting down
   output logic                      counter_overflow_flag, // Sticky overflow flag
   output logic                      overflow_irq,       // Overflow interrupt request
   output logic [NUM_CH-1:0]         channel_event_flag, // Sticky channel flags
   output logic [NUM_CH-1:0]         channel_irq         // Channel interrupt requests
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
      $error("NUM_CH must lie between 1 and 8");
   end

   // ************************************************************
   // Counter
   // ************************************************************
   logic [15:0] counter_ff;      // Running count
   logic [15:0] nxt_counter;     // Next count
   logic        down_ff;         // Direction, high when counting down
   logic        nxt_down;        // Next direction
   logic        ovf_event;       // Overflow condition this cycle
   logic [15:0] top;             // Effective terminal count

   // Terminal count is the modulus, or ffff with no limit
   assign top = (modulus == tefl_pkg::MOD_NONE) ? tefl_pkg::CNT_MAX : modulus;

   // Next count and overflow detection for both counting modes
   always_comb begin
      nxt_counter = counter_ff;
      nxt_down    = down_ff;
      ovf_event   = 1'b0;
      if (center_aligned_pwm) begin
         // Modulus zero turns at ffff; keep the modulus in range for usable periods
         if (!down_ff) begin
            if (counter_ff >= top) begin
               nxt_counter = counter_ff - 16'h0001;
               nxt_down    = 1'b1;
               ovf_event   = 1'b1;
            end else begin
               nxt_counter = counter_ff + 16'h0001;
            end
         end else begin
            if (counter_ff == tefl_pkg::CNT_ZERO) begin
               // Zero is the period center, no flag here
               nxt_counter = counter_ff + 16'h0001;
               nxt_down    = 1'b0;
            end else begin
               nxt_counter = counter_ff - 16'h0001;
            end
         end
      end else begin
         nxt_down = 1'b0;
         if (counter_ff == top) begin
            nxt_counter = tefl_pkg::CNT_ZERO;
            ovf_event   = 1'b1;
         end else begin
            nxt_counter = counter_ff + 16'h0001;
         end
      end
   end

   // Counter and direction registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         counter_ff <= tefl_pkg::CNT_RST;
         down_ff    <= 1'b0;
      end else begin
         counter_ff <= nxt_counter;
         down_ff    <= nxt_down;
      end
   end

   assign counter    = counter_ff;
   assign count_down = down_ff;

   // ************************************************************
   // Overflow flag with two-step clear
   // ************************************************************
   logic ovf_ff;        // Overflow flag
   logic ovf_armed_ff;  // Flag was read while set, clear may follow

   // A new event disarms the clear so it is never lost
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ovf_ff       <= 1'b0;
         ovf_armed_ff <= 1'b0;
      end else begin
         if (ovf_event) begin
            ovf_ff       <= 1'b1;
            ovf_armed_ff <= 1'b0;
         end else if (ovf_flag_write_zero && ovf_armed_ff) begin
            ovf_ff       <= 1'b0;
            ovf_armed_ff <= 1'b0;
         end else if (ovf_flag_read && ovf_ff) begin
            ovf_armed_ff <= 1'b1;
         end
      end
   end

   assign counter_overflow_flag = ovf_ff;
   assign overflow_irq          = ovf_ff & overflow_irq_enable;

   // ************************************************************
   // Channel event flags
   // ************************************************************
   logic [NUM_CH-1:0] pin_meta_ff;  // First synchroniser stage
   logic [NUM_CH-1:0] pin_sync_ff;  // Second synchroniser stage
   logic [NUM_CH-1:0] pin_prev_ff;  // Previous synced level for edges
   logic [NUM_CH-1:0] ch_ff;        // Channel flags
   logic [NUM_CH-1:0] ch_armed_ff;  // Read-while-set seen per channel
   logic [NUM_CH-1:0] ch_event;     // Event per channel this cycle
   logic [2:0]        settle_ff;    // Ones shift in while the sync pipeline fills

   // Pins are asynchronous, two stages before edge logic
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
         pin_prev_ff <= '0;
      end else begin
         pin_meta_ff <= channel_pin;
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   // Edges are masked until the pipeline holds real pin levels, so a pin
   // that idles high gives no false rising edge after reset; the cost is
   // that a pin change before the first clock edge after reset is not captured
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         settle_ff <= 3'h0;
      end else begin
         settle_ff <= {settle_ff[1:0], 1'b1};
      end
   end

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      tefl_pkg::tefl_ch_mode_type mode;   // This channel's mode
      logic [1:0]  esel;                  // Edge select
      logic [15:0] cval;                  // Channel value
      logic        rise;                  // Synced rising edge
      logic        fall;                  // Synced falling edge
      logic        match;                 // Counter equals channel value

      assign mode  = tefl_pkg::tefl_ch_mode_type'(channel_mode[2*i +: 2]);
      assign esel  = channel_edge_select[2*i +: 2];
      assign cval  = channel_value[16*i +: 16];
      assign rise  = settle_ff[2] & pin_sync_ff[i] & ~pin_prev_ff[i];
      assign fall  = settle_ff[2] & ~pin_sync_ff[i] & pin_prev_ff[i];
      // Match is sampled once per count value, so each crossing gives one event
      assign match = (counter_ff == cval);

      // Event source chosen by channel mode
      always_comb begin
         case (mode)
            tefl_pkg::TEFL_CAPTURE: begin
               case (esel)
                  tefl_pkg::EDGE_RISE: ch_event[i] = rise;
                  tefl_pkg::EDGE_FALL: ch_event[i] = fall;
                  tefl_pkg::EDGE_ANY:  ch_event[i] = rise | fall;
                  default:             ch_event[i] = 1'b0;
               endcase
            end
            tefl_pkg::TEFL_COMPARE:    ch_event[i] = match;
            // Up-count only, so one match per period
            tefl_pkg::TEFL_EDGE_PWM:   ch_event[i] = match & ~center_aligned_pwm;
            // Counter passes the value up and down, giving two matches
            tefl_pkg::TEFL_CENTER_PWM: ch_event[i] = match & center_aligned_pwm;
            default:                   ch_event[i] = 1'b0;
         endcase
      end

      // Flag with two-step clear; event wins and restarts the sequence
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            ch_ff[i]       <= 1'b0;
            ch_armed_ff[i] <= 1'b0;
         end else begin
            if (ch_event[i]) begin
               ch_ff[i]       <= 1'b1;
               ch_armed_ff[i] <= 1'b0;
            end else if (ch_flag_write_zero[i] && ch_armed_ff[i]) begin
               ch_ff[i]       <= 1'b0;
               ch_armed_ff[i] <= 1'b0;
            end else if (ch_flag_read[i] && ch_ff[i]) begin
               ch_armed_ff[i] <= 1'b1;
            end
         end
      end
   end

   assign channel_event_flag = ch_ff;
   assign channel_irq        = ch_ff & channel_irq_enable;

endmodule // tefl_timer_event_flags
`default_nettype wire

// File: verification/tefl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tefl_monitor #(
   parameter int NUM_CH = 2                    // Channel count
) (
   input wire logic                 clock,
   input wire logic                 rst_n,
   input wire logic [15:0]          modulus,
   input wire logic                 center_aligned_pwm,
   input wire logic                 overflow_irq_enable,
   input wire logic                 ovf_flag_write_zero,
   input wire logic [2*NUM_CH-1:0]  channel_mode,
   input wire logic [16*NUM_CH-1:0] channel_value,
   input wire logic [NUM_CH-1:0]    channel_irq_enable,
   input wire logic [NUM_CH-1:0]    ch_flag_write_zero,
   input wire logic [15:0]          counter,
   input wire logic                 count_down,
   input wire logic                 counter_overflow_flag,
   input wire logic                 overflow_irq,
   input wire logic [NUM_CH-1:0]    channel_event_flag,
   input wire logic [NUM_CH-1:0]    channel_irq
);
   // ****************************************
   // Turnaround count and channel 0 match
   // ****************************************
   logic [15:0] top;                           // Zero modulus means full range
   logic        hit0;                          // Channel 0 value equals count
   assign top  = (modulus == 16'h0000) ? 16'hffff : modulus;
   assign hit0 = (counter == channel_value[15:0]);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ****************************************
   // Checks
   // ****************************************
   // Up-count wrap at the terminal count raises the flag
   ovf_up_a: assert property (!center_aligned_pwm && counter == top
      |=> counter == 16'h0000 && counter_overflow_flag)
      else $error("overflow not set at up-count wrap");
   // Below the top the count steps by exactly one
   cnt_step_a: assert property (!center_aligned_pwm && !count_down && counter != top
      |=> counter == $past(counter) + 16'h0001)
      else $error("up count did not advance by one");
   // A new overflow flag only ever follows the terminal count
   ovf_only_top_a: assert property ($rose(counter_overflow_flag) |-> $past(counter) >= $past(top))
      else $error("overflow flag set away from terminal count");
   ovf_turn_a: assert property (center_aligned_pwm && !count_down && counter >= top
      |=> count_down && counter_overflow_flag)
      else $error("no turnaround overflow at modulus");
   zero_turn_a: assert property (center_aligned_pwm && count_down && counter == 16'h0000
      |=> !count_down)
      else $error("down count did not turn at zero");
   cmp_flag_a: assert property (channel_mode[1:0] == tefl_pkg::TEFL_COMPARE && hit0
      |=> channel_event_flag[0])
      else $error("compare match did not set flag");
   epwm_flag_a: assert property (!center_aligned_pwm && channel_mode[1:0] == tefl_pkg::TEFL_EDGE_PWM && hit0
      |=> channel_event_flag[0])
      else $error("edge pwm match did not set flag");
   center_aligned_pwm_flag_a: assert property (center_aligned_pwm && channel_mode[1:0] == tefl_pkg::TEFL_CENTER_PWM && hit0
      |=> channel_event_flag[0])
      else $error("center pwm match did not set flag");
   // Requests are pure levels of flag and enable
   irq_level_a: assert property (overflow_irq == (counter_overflow_flag && overflow_irq_enable)
      && channel_irq == (channel_event_flag & channel_irq_enable))
      else $error("interrupt request does not follow flag and enable");
   flag_clear_a: assert property ($fell(counter_overflow_flag) |-> $past(ovf_flag_write_zero))
      else $error("overflow flag cleared without zero write");
   ch_clear_a: assert property ($fell(channel_event_flag[0]) |-> $past(ch_flag_write_zero[0]))
      else $error("channel flag cleared without zero write");
   cover property ($rose(counter_overflow_flag));
   cover property ($rose(channel_event_flag[0]));
   cover property ($rose(count_down));
endmodule // tefl_monitor
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clock = 1'b0;  // Low before any process runs, so no edge is seen at time zero
   logic        rst_n, center_aligned_pwm, overflow_irq_enable, ovf_flag_read, ovf_flag_write_zero;
   logic [15:0] modulus, counter;
   logic [3:0]  channel_mode, channel_edge_select;
   logic [31:0] channel_value;
   logic [1:0]  channel_pin, channel_irq_enable, ch_flag_read, ch_flag_write_zero, channel_event_flag, channel_irq;
   logic        count_down, counter_overflow_flag, overflow_irq;
   int          err_total, n_checks, m, e;
   tefl_timer_event_flags #(.NUM_CH(2)) i_dut (.clock(clock), .rst_n(rst_n), .modulus(modulus),
      .center_aligned_pwm(center_aligned_pwm), .overflow_irq_enable(overflow_irq_enable),
      .ovf_flag_read(ovf_flag_read), .ovf_flag_write_zero(ovf_flag_write_zero), .channel_mode(channel_mode),
      .channel_edge_select(channel_edge_select), .channel_value(channel_value), .channel_pin(channel_pin),
      .channel_irq_enable(channel_irq_enable), .ch_flag_read(ch_flag_read), .ch_flag_write_zero(ch_flag_write_zero),
      .counter(counter), .count_down(count_down), .counter_overflow_flag(counter_overflow_flag),
      .overflow_irq(overflow_irq), .channel_event_flag(channel_event_flag), .channel_irq(channel_irq));
   // ****************************************
   // Helpers, all inputs move at the falling edge
   // ****************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Bounded wait; a full free-running lap fits in the bound
   task automatic wait_cnt(input logic [15:0] v);
      for (int i = 0; i < 70000 && counter !== v; i++) @(negedge clock);
      if (counter !== v) begin
         err_total++;
         give_verdict();
      end
   endtask
   // Two-step clear: read pulse, then zero-write pulse
   task automatic clr_ovf();
      ovf_flag_read = 1'b1;
      tick(1);
      ovf_flag_read = 1'b0;
      ovf_flag_write_zero = 1'b1;
      tick(1);
      ovf_flag_write_zero = 1'b0;
      tick(1);
   endtask
   task automatic clr_ch(input int c);
      ch_flag_read[c] = 1'b1;
      tick(1);
      ch_flag_read[c] = 1'b0;
      ch_flag_write_zero[c] = 1'b1;
      tick(1);
      ch_flag_write_zero[c] = 1'b0;
      tick(1);
   endtask
   // Free-running 4 ns clock
   initial begin
      forever #2 clock = ~clock;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      // All inputs idle, reset held for three clock cycles
      rst_n               = 1'b0;
      center_aligned_pwm  = 1'b0;
      ovf_flag_read       = 1'b0;
      ovf_flag_write_zero = 1'b0;
      channel_mode        = 4'h0;
      channel_edge_select = 4'h0;
      channel_pin         = 2'h0;
      ch_flag_read        = 2'h0;
      ch_flag_write_zero  = 2'h0;
      modulus             = 16'h0040;
      channel_value       = 32'h0000_0010;
      channel_irq_enable  = 2'h1;
      overflow_irq_enable = 1'b1;
      tick(3);
      rst_n = 1'b1;
      // Modulus wrap sets the flag, a lone zero write is ignored
      wait_cnt(16'h0040);
      tick(1);
      chk(counter, 16'h0000);
      chk(counter_overflow_flag, 16'h0001);
      chk(overflow_irq, 16'h0001);
      ovf_flag_write_zero = 1'b1;
      tick(1);
      ovf_flag_write_zero = 1'b0;
      chk(counter_overflow_flag, 16'h0001);
      // A new wrap between read and write keeps the flag
      wait_cnt(16'h003f);
      ovf_flag_read = 1'b1;
      tick(1);
      ovf_flag_read = 1'b0;
      tick(2);
      ovf_flag_write_zero = 1'b1;
      tick(1);
      ovf_flag_write_zero = 1'b0;
      chk(counter_overflow_flag, 16'h0001);
      // Request drops with its enable while the flag stays
      overflow_irq_enable = 1'b0;
      tick(1);
      chk(overflow_irq, 16'h0000);
      chk(counter_overflow_flag, 16'h0001);
      clr_ovf();
      chk(counter_overflow_flag, 16'h0000);
      // Free-running lap passes the old modulus and wraps only at the top
      modulus = 16'h0000;
      clr_ovf();
      wait_cnt(16'hffff);
      chk(counter_overflow_flag, 16'h0000);
      tick(1);
      chk(counter, 16'h0000);
      chk(counter_overflow_flag, 16'h0001);
      // Compare then edge PWM on channel 0
      modulus = 16'h0040;
      for (m = 1; m < 3; m++) begin
         channel_mode[1:0] = 2'(m);
         wait_cnt(16'h0020);
         clr_ch(0);
         chk(channel_event_flag[0], 16'h0000);
         wait_cnt(16'h0010);
         tick(1);
         chk(channel_event_flag[0], 16'h0001);
         chk(channel_irq[0], 16'h0001);
      end
      // Every edge code on channel 1, two sync flops plus edge stage
      for (e = 0; e < 4; e++) begin
         channel_edge_select[3:2] = 2'(e);
         clr_ch(1);
         channel_pin[1] = 1'b1;
         tick(6);
         chk(channel_event_flag[1], 16'(e[0]));
         clr_ch(1);
         channel_pin[1] = 1'b0;
         tick(6);
         chk(channel_event_flag[1], 16'(e[1]));
         chk(channel_irq[1], 16'h0000);
      end
      // Center-aligned: turn at modulus, match both ways, zero is mid-period
      center_aligned_pwm = 1'b1;
      modulus = 16'h0020;
      channel_mode[1:0] = 2'h3;
      wait_cnt(16'h0008);
      clr_ovf();
      clr_ch(0);
      wait_cnt(16'h0020);
      chk(counter_overflow_flag, 16'h0000);
      tick(1);
      chk(count_down, 16'h0001);
      chk(counter_overflow_flag, 16'h0001);
      chk(channel_event_flag[0], 16'h0001);
      clr_ch(0);
      clr_ovf();
      wait_cnt(16'h0010);
      chk(channel_event_flag[0], 16'h0000);
      tick(1);
      chk(channel_event_flag[0], 16'h0001);
      wait_cnt(16'h0000);
      tick(2);
      chk(count_down, 16'h0000);
      chk(counter_overflow_flag, 16'h0000);
      give_verdict();
   end
endmodule // tb_top
bind tefl_timer_event_flags tefl_monitor #(.NUM_CH(NUM_CH)) i_mon (.clock(clock), .rst_n(rst_n),
   .modulus(modulus), .center_aligned_pwm(center_aligned_pwm), .overflow_irq_enable(overflow_irq_enable),
   .ovf_flag_write_zero(ovf_flag_write_zero), .channel_mode(channel_mode), .channel_value(channel_value),
   .channel_irq_enable(channel_irq_enable), .ch_flag_write_zero(ch_flag_write_zero),
   .counter(counter), .count_down(count_down),
   .counter_overflow_flag(counter_overflow_flag), .overflow_irq(overflow_irq),
   .channel_event_flag(channel_event_flag), .channel_irq(channel_irq));
`default_nettype wire
